//--- logic/qep_regs.vh
// Register map, field layout and constants of the quadrature encoder block
//
// Function
// - Direction flag keeps last seen rotation direction
// - Both inputs changing together in quadrature mode sets sticky error
// - Four interrupt sources, each with own enable
// - Software reads raw and masked interrupt status
// - Write-one clears selected interrupt source flags
// - Position readable; index alignment after first index
// - Software write loads position counter
// - Velocity predivider 1 to 128 in powers two
// - Only position-changing pulses feed velocity accumulator
// - Period end saves velocity, restarts accumulator
// - Velocity needs velocity enable and main enable
// - Main enable cleared stops all encoder processing
// - Count edges of channel A or both
// - Index reset mode clears position on forward index
// - Quadrature or step/direction decode, optional swap
// - Maximum position bounds counter, loaded reverse index
`ifndef QEP_REGS_VH
`define QEP_REGS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define QEP_CTRL_OFF      12'h000
`define QEP_STAT_OFF      12'h004
`define QEP_POS_OFF       12'h008
`define QEP_MAXPOS_OFF    12'h00C
`define QEP_LOAD_OFF      12'h010
`define QEP_PERIOD_OFF    12'h014
`define QEP_VELCNT_OFF    12'h018
`define QEP_VEL_OFF       12'h01C
`define QEP_IMASK_OFF     12'h020
`define QEP_IRAW_OFF      12'h024
`define QEP_IMSK_STAT_OFF 12'h028
`define QEP_ICLR_OFF      12'h02C

// ==========================================================================
// Control fields
`define QEP_CTRL_EN       0
`define QEP_CTRL_SWAP     1
`define QEP_CTRL_STEPDIR  2
`define QEP_CTRL_CAP_AB   3
`define QEP_CTRL_RST_IDX  4
`define QEP_CTRL_VEL_EN   5
`define QEP_CTRL_DIV_LO   6
`define QEP_CTRL_DIV_HI   8

// Status fields
`define QEP_STAT_ERR      0
`define QEP_STAT_DIR      1

// Interrupt bits
`define QEP_INT_ERR       0
`define QEP_INT_DIR       1
`define QEP_INT_TIMER     2
`define QEP_INT_INDEX     3

// Reset values
`define QEP_CTRL_RST      9'h000
`define QEP_MAXPOS_RST    32'hFFFFFFFF
`define QEP_PERIOD_RST    32'h00000001

`endif

//--- logic/qep_sync.v
// Two-flop synchroniser for the encoder pins
module qep_sync #(
    parameter W = 3
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // qep_sync

//--- logic/qep_top.v
// Quadrature encoder: position, direction, error, velocity, APB registers
//
// The APB interface to the registers and the address map were decided locally.
`include "qep_regs.vh"

module qep_top (
    // Clock and reset
    input  wire        I_SYS_CLK,
    input  wire        I_RSTN,
    // APB slave
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [11:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output reg         O_PREADY,
    output reg         O_PSLVERR,
    // Encoder pins
    input  wire        I_CHA,
    input  wire        I_CHB,
    input  wire        I_IDX,
    // Interrupt
    output reg         O_IRQ
);
    // ======================================================================
    // Pin synchronisers
    wire [2:0] pins_s;

    qep_sync #(
        .W (3)
    ) u_sync (
        .clk   (I_SYS_CLK),
        .rst_n (I_RSTN),
        .d     ({I_IDX, I_CHB, I_CHA}),
        .q     (pins_s)
    );

    // ======================================================================
    // Registers
    reg  [8:0]  ctrl_q;
    reg  [31:0] max_position_value_q;
    reg  [31:0] velocity_period_ticks_q;
    reg  [3:0]  imask_q;
    reg  [3:0]  iraw_q;
    reg  [31:0] pos_q;
    reg  [31:0] velcnt_q;
    reg  [31:0] vel_q;
    reg  [31:0] timer_q;
    reg  [6:0]  prediv_q;
    reg         dir_q;
    reg         err_q;
    reg         idx_seen_q;
    reg  [2:0]  prev_q;

    wire        en       = ctrl_q[`QEP_CTRL_EN];
    wire        swap     = ctrl_q[`QEP_CTRL_SWAP];
    wire        step_dir = ctrl_q[`QEP_CTRL_STEPDIR];
    wire        cap_ab   = ctrl_q[`QEP_CTRL_CAP_AB];
    wire        reset_on_index = ctrl_q[`QEP_CTRL_RST_IDX];
    wire        vel_en   = ctrl_q[`QEP_CTRL_VEL_EN] & en;
    wire [2:0]  velocity_predivider =
                ctrl_q[`QEP_CTRL_DIV_HI:`QEP_CTRL_DIV_LO];

    // APB decode
    wire        wr_acc = I_PSEL & I_PENABLE & I_PWRITE;
    wire        rd_acc = I_PSEL & I_PENABLE & ~I_PWRITE;
    wire        wr_ctrl  = wr_acc && I_PADDR == `QEP_CTRL_OFF;
    wire        wr_max   = wr_acc && I_PADDR == `QEP_MAXPOS_OFF;
    wire        wr_load  = wr_acc && I_PADDR == `QEP_LOAD_OFF;
    wire        wr_per   = wr_acc && I_PADDR == `QEP_PERIOD_OFF;
    wire        wr_mask  = wr_acc && I_PADDR == `QEP_IMASK_OFF;
    wire        wr_iclr  = wr_acc && I_PADDR == `QEP_ICLR_OFF;
    wire        wr_stat  = wr_acc && I_PADDR == `QEP_STAT_OFF;

    // ======================================================================
    // Channel swap and decode
    wire        ch_a = swap ? pins_s[1] : pins_s[0];
    wire        ch_b = swap ? pins_s[0] : pins_s[1];
    wire        pa   = swap ? prev_q[1] : prev_q[0];
    wire        pb   = swap ? prev_q[0] : prev_q[1];
    wire        a_chg = ch_a ^ pa;
    wire        b_chg = ch_b ^ pb;
    wire        idx_rise = pins_s[2] & ~prev_q[2];

    reg         step;
    reg         fwd;
    reg         phase_err;

    always @* begin
        step      = 1'b0;
        fwd       = dir_q;
        phase_err = 1'b0;
        if (en) begin
            if (step_dir) begin
                // Channel A is the step clock, B the direction
                step = ch_a & ~pa;
                fwd  = ~ch_b;
            end else if (a_chg & b_chg) begin
                phase_err = 1'b1;
            end else if (a_chg) begin
                step = 1'b1;
                fwd  = ch_a ^ ch_b;
            end else if (b_chg) begin
                step = cap_ab;
                fwd  = ~(ch_a ^ ch_b);
            end
        end
    end

    // Next position; counter wraps within 0..max
    reg  [31:0] pos_d;

    always @* begin
        pos_d = pos_q;
        if (wr_load) begin
            pos_d = I_PWDATA;
        end else if (en && reset_on_index && idx_rise) begin
            pos_d = fwd ? 32'h00000000 : max_position_value_q;
        end else if (step) begin
            if (fwd)
                pos_d = (pos_q >= max_position_value_q) ? 32'h00000000
                                                        : pos_q + 32'h1;
            else
                pos_d = (pos_q == 32'h00000000) ? max_position_value_q
                                                : pos_q - 32'h1;
        end
    end

    // ======================================================================
    // Velocity predivider and timer
    wire [6:0]  div_mask = (7'h01 << velocity_predivider) - 7'h01;
    wire        vel_pulse = vel_en & step &
                            ((prediv_q & div_mask) == div_mask);
    wire        period_end = vel_en &&
                             timer_q >= velocity_period_ticks_q - 32'h1;

    // ======================================================================
    // Events
    wire        dir_change = step & (fwd != dir_q);
    wire        idx_evt    = en & idx_rise;
    wire [3:0]  evt;

    assign evt[`QEP_INT_ERR]   = phase_err;
    assign evt[`QEP_INT_DIR]   = dir_change;
    assign evt[`QEP_INT_TIMER] = period_end;
    assign evt[`QEP_INT_INDEX] = idx_evt;

    // ======================================================================
    // Interrupt next state
    wire [3:0]  clr_bits = wr_iclr ? I_PWDATA[3:0] : 4'h0;
    // Set wins over write-one-to-clear in the same cycle
    wire [3:0]  iraw_d   = (iraw_q & ~clr_bits) | evt;
    wire [3:0]  imask_d  = wr_mask ? I_PWDATA[3:0] : imask_q;

    // ======================================================================
    // Configuration registers
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_q                  <= `QEP_CTRL_RST;
            max_position_value_q    <= `QEP_MAXPOS_RST;
            velocity_period_ticks_q <= `QEP_PERIOD_RST;
            imask_q                 <= 4'h0;
        end else begin
            if (wr_ctrl)
                ctrl_q <= I_PWDATA[8:0];
            if (wr_max)
                max_position_value_q <= I_PWDATA;
            // Zero period is illegal; keep old value instead
            if (wr_per && I_PWDATA != 32'h00000000)
                velocity_period_ticks_q <= I_PWDATA;
            imask_q <= imask_d;
        end
    end

    // ======================================================================
    // Raw interrupt flags
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            iraw_q <= 4'h0;
        end else begin
            iraw_q <= iraw_d;
        end
    end

    // ======================================================================
    // Interrupt line
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_IRQ <= 1'b0;
        end else begin
            // Uses next flags and mask so the line tracks the registers
            O_IRQ <= |(iraw_d & imask_d);
        end
    end

    // ======================================================================
    // Pin history
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            prev_q <= 3'h0;
        end else begin
            // Tracked while disabled too, so enabling sees no stale edge
            prev_q <= pins_s;
        end
    end

    // ======================================================================
    // Position counter
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pos_q <= 32'h00000000;
        end else begin
            pos_q <= pos_d;
        end
    end

    // ======================================================================
    // Direction
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            dir_q <= 1'b1;
        end else if (step) begin
            // Only a counted step updates it; standing still keeps it
            dir_q <= fwd;
        end
    end

    // ======================================================================
    // Phase error
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            err_q <= 1'b0;
        end else if (phase_err) begin
            // Set wins over a software clear in the same cycle
            err_q <= 1'b1;
        end else if (wr_stat && I_PWDATA[`QEP_STAT_ERR]) begin
            err_q <= 1'b0;
        end
    end

    // ======================================================================
    // Index seen since enable
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            idx_seen_q <= 1'b0;
        end else if (idx_evt) begin
            idx_seen_q <= 1'b1;
        end else if (!en) begin
            // Disable forgets alignment; next index must be seen again
            idx_seen_q <= 1'b0;
        end
    end

    // ======================================================================
    // Velocity predivider
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            prediv_q <= 7'h00;
        end else if (!vel_en) begin
            prediv_q <= 7'h00;
        end else if (step) begin
            // Advances only on counted steps, never on the ticks
            prediv_q <= (prediv_q & div_mask) == div_mask
                        ? 7'h00 : prediv_q + 7'h01;
        end
    end

    // ======================================================================
    // Velocity period timer
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            timer_q <= 32'h00000000;
        end else if (!vel_en || period_end) begin
            timer_q <= 32'h00000000;
        end else begin
            timer_q <= timer_q + 32'h1;
        end
    end

    // ======================================================================
    // Velocity accumulator
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            velcnt_q <= 32'h00000000;
        end else if (!vel_en || period_end) begin
            // Restarts from zero; the closed count moves to the result
            velcnt_q <= 32'h00000000;
        end else if (vel_pulse) begin
            velcnt_q <= velcnt_q + 32'h1;
        end
    end

    // ======================================================================
    // Velocity result
    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            vel_q <= 32'h00000000;
        end else if (period_end) begin
            // A pulse in the closing cycle still belongs to this period
            vel_q <= velcnt_q + (vel_pulse ? 32'h1 : 32'h0);
        end
    end

    // ======================================================================
    // APB read path; one wait-free access phase
    reg  [31:0] rdata_d;
    reg         addr_ok;

    always @* begin
        rdata_d = 32'h00000000;
        addr_ok = 1'b1;
        case (I_PADDR)
            `QEP_CTRL_OFF:      rdata_d = {23'h0, ctrl_q};
            `QEP_STAT_OFF:      rdata_d = {29'h0, idx_seen_q, dir_q, err_q};
            `QEP_POS_OFF:       rdata_d = pos_q;
            `QEP_MAXPOS_OFF:    rdata_d = max_position_value_q;
            `QEP_LOAD_OFF:      rdata_d = pos_q;
            `QEP_PERIOD_OFF:    rdata_d = velocity_period_ticks_q;
            `QEP_VELCNT_OFF:    rdata_d = velcnt_q;
            `QEP_VEL_OFF:       rdata_d = vel_q;
            `QEP_IMASK_OFF:     rdata_d = {28'h0, imask_q};
            `QEP_IRAW_OFF:      rdata_d = {28'h0, iraw_q};
            `QEP_IMSK_STAT_OFF: rdata_d = {28'h0, iraw_q & imask_q};
            `QEP_ICLR_OFF:      rdata_d = 32'h00000000;
            default:            addr_ok = 1'b0;
        endcase
    end

    always @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PRDATA  <= 32'h00000000;
            O_PREADY  <= 1'b0;
            O_PSLVERR <= 1'b0;
        end else begin
            // Registered answer: setup cycle prepares, access completes
            O_PREADY  <= I_PSEL & ~I_PENABLE;
            O_PSLVERR <= I_PSEL & ~I_PENABLE & ~addr_ok;
            if (I_PSEL && !I_PENABLE && !I_PWRITE)
                O_PRDATA <= rdata_d;
        end
    end
endmodule // qep_top

//--- verification/qep_props.sv
// Checker: bus handshake and interrupt relations at the block ports
`include "qep_regs.vh"
module qep_props (
    input wire        I_SYS_CLK,
    input wire        I_RSTN,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [11:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire [31:0] O_PRDATA,
    input wire        O_PREADY,
    input wire        O_PSLVERR,
    input wire        O_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RSTN);
    wire setup = I_PSEL && !I_PENABLE;
    wire mask_off = I_PSEL && I_PENABLE && I_PWRITE &&
        I_PADDR == `QEP_IMASK_OFF && I_PWDATA[3:0] == 4'h0;
    // ======
    // Assertions
    rdy_after_setup_a: assert property (setup |=> O_PREADY)
        else $error("ready missing after setup");
    rdy_pulse_a: assert property (O_PREADY |=> !O_PREADY)
        else $error("ready longer than one cycle");
    rdy_access_a: assert property (O_PREADY |-> I_PSEL && I_PENABLE)
        else $error("ready outside access phase");
    err_with_rdy_a: assert property (O_PSLVERR |-> O_PREADY)
        else $error("error without ready");
    err_read_zero_a: assert property (
        O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (
        !(setup && !I_PWRITE) |=> $stable(O_PRDATA))
        else $error("read data moved without read");
    mask_off_a: assert property (mask_off |=> ##1 !O_IRQ)
        else $error("irq high with all sources masked");
    irq_reset_a: assert property ($rose(I_RSTN) |-> !O_IRQ)
        else $error("irq high out of reset");
    cover property (O_PSLVERR);
    cover property ($rose(O_IRQ));
    cover property (O_PREADY && !I_PWRITE);
endmodule // qep_props

bind qep_top qep_props qep_props_i (.I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN),
    .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
    .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_IRQ(O_IRQ));

//--- verification/qep_enc_model.sv
// Behavioural rotary encoder: two phases and an index pulse
module qep_enc_model (
    input  wire logic clk,
    output logic      o_a,
    output logic      o_b,
    output logic      o_idx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph = 2'h0;
    logic [2:0] cnt = 3'h0;
    logic       run = 1'b0;
    // Gray order 00,10,11,01 is forward
    assign o_a = ph[0] ^ ph[1];
    assign o_b = ph[1];
    initial o_idx = 1'b0;
    // Free run: one edge every five clocks, exact for window math
    always @(posedge clk) begin
        cnt <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
        if (run && cnt == 3'h4)
            ph <= ph + 2'h1;
    end
    task automatic step(input logic fwd, input logic [1:0] inc = 2'h1);
        @(posedge clk);
        ph <= fwd ? ph + inc : ph - inc;
        repeat (6) @(posedge clk);
    endtask
    // Free running starts on request and never stops
    task automatic spin();
        @(posedge clk);
        run <= 1'b1;
    endtask
    task automatic pulse();
        @(posedge clk);
        o_idx <= 1'b1;
        repeat (4) @(posedge clk);
        o_idx <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule // qep_enc_model

//--- verification/qep_top_test.sv
// Self-checking bench for the quadrature encoder block
`include "qep_regs.vh"
module qep_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, pen, pwr, erq;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         prdy, perr, irq, cha, chb, idx;
    int          n_errors, cmp_count;
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    qep_top qep_top_i (.I_SYS_CLK(clk), .I_RSTN(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(prdy), .O_PSLVERR(perr),
        .I_CHA(cha), .I_CHB(chb), .I_IDX(idx), .O_IRQ(irq));
    qep_enc_model qep_enc_model_i (.clk(clk), .o_a(cha),
        .o_b(chb), .o_idx(idx));
    // ======
    // Helpers
    task automatic check(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Waits for ready under a bound; no fixed wait-state count assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (prdy !== 1'b1 && n < 20);
        if (prdy !== 1'b1) begin
            n_errors++;
            report_and_stop;
        end
        rd = prdata;
        erq = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(nm, rd, e);
    endtask
    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask
    // ======
    // Scenarios
    task t_reset;
        rdc("ctrl", `QEP_CTRL_OFF, 32'h0);
        rdc("maxpos", `QEP_MAXPOS_OFF, 32'hFFFFFFFF);
        rdc("period", `QEP_PERIOD_OFF, 32'h1);
        rdc("stat", `QEP_STAT_OFF, 32'h2);
        rdc("unmapped", 12'h030, 32'h0);
        check("slverr", {31'h0, erq}, 32'h1);
        $display("reset test done");
    endtask
    task t_pos;
        wr(`QEP_MAXPOS_OFF, 32'h9);
        wr(`QEP_CTRL_OFF, 32'h1);
        repeat (4) qep_enc_model_i.step(1'b1);
        rdc("pos a only", `QEP_POS_OFF, 32'h2);
        wr(`QEP_CTRL_OFF, 32'h0);
        wr(`QEP_CTRL_OFF, 32'h9);
        repeat (4) qep_enc_model_i.step(1'b1);
        repeat (2) qep_enc_model_i.step(1'b0);
        rdc("pos ab", `QEP_POS_OFF, 32'h4);
        rdc("stat rev", `QEP_STAT_OFF, 32'h0);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("raw dir", rd & 32'h2, 32'h2);
        wr(`QEP_LOAD_OFF, 32'h7);
        repeat (3) qep_enc_model_i.step(1'b1);
        rdc("pos wrap", `QEP_POS_OFF, 32'h0);
        wr(`QEP_CTRL_OFF, 32'h0);
        repeat (2) qep_enc_model_i.step(1'b1);
        rdc("pos held", `QEP_POS_OFF, 32'h0);
        $display("position test done");
    endtask
    task t_irq;
        wr(`QEP_ICLR_OFF, 32'hF);
        wr(`QEP_IMASK_OFF, 32'h1);
        wr(`QEP_CTRL_OFF, 32'h9);
        qep_enc_model_i.step(1'b1, 2'h2);
        apb(1'b0, `QEP_STAT_OFF, 32'h0);
        check("err flag", rd & 32'h1, 32'h1);
        rdc("masked", `QEP_IMSK_STAT_OFF, 32'h1);
        irq_is(1'b1);
        wr(`QEP_IMASK_OFF, 32'h0);
        irq_is(1'b0);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("raw err", rd & 32'h1, 32'h1);
        wr(`QEP_IMASK_OFF, 32'h1);
        irq_is(1'b1);
        wr(`QEP_ICLR_OFF, 32'h1);
        irq_is(1'b0);
        $display("interrupt test done");
    endtask
    task t_index;
        wr(`QEP_CTRL_OFF, 32'h0);
        wr(`QEP_CTRL_OFF, 32'h19);
        repeat (2) qep_enc_model_i.step(1'b1);
        qep_enc_model_i.pulse();
        rdc("idx fwd", `QEP_POS_OFF, 32'h0);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("raw idx", rd & 32'h8, 32'h8);
        repeat (2) qep_enc_model_i.step(1'b0);
        qep_enc_model_i.pulse();
        rdc("idx rev", `QEP_POS_OFF, 32'h9);
        $display("index test done");
    endtask
    task t_mode;
        wr(`QEP_CTRL_OFF, 32'h0);
        wr(`QEP_LOAD_OFF, 32'h5);
        wr(`QEP_CTRL_OFF, 32'hB);
        repeat (2) qep_enc_model_i.step(1'b1);
        rdc("pos swap", `QEP_POS_OFF, 32'h3);
        apb(1'b0, `QEP_STAT_OFF, 32'h0);
        check("dir swap", rd & 32'h2, 32'h0);
        wr(`QEP_CTRL_OFF, 32'h0);
        wr(`QEP_ICLR_OFF, 32'h2);
        wr(`QEP_CTRL_OFF, 32'h5);
        repeat (2) qep_enc_model_i.step(1'b1);
        rdc("pos stepdir", `QEP_POS_OFF, 32'h4);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("raw dir fwd", rd & 32'h2, 32'h2);
        $display("mode test done");
    endtask
    task t_vel;
        qep_enc_model_i.spin();
        wr(`QEP_ICLR_OFF, 32'h4);
        wr(`QEP_CTRL_OFF, 32'h28);
        repeat (50) @(posedge clk);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("timer off", rd & 32'h4, 32'h0);
        wr(`QEP_CTRL_OFF, 32'h9);
        repeat (50) @(posedge clk);
        rdc("velcnt off", `QEP_VELCNT_OFF, 32'h0);
        for (int d = 0; d < 8; d++) begin
            wr(`QEP_CTRL_OFF, 32'h0);
            wr(`QEP_PERIOD_OFF, 32'h28 << d);
            wr(`QEP_CTRL_OFF, 32'h29 | (d << 6));
            repeat ((40 << d) * 3) @(posedge clk);
            rdc("velocity", `QEP_VEL_OFF, 32'h8);
        end
        wr(`QEP_PERIOD_OFF, 32'h0);
        rdc("period kept", `QEP_PERIOD_OFF, 32'h1400);
        apb(1'b0, `QEP_IRAW_OFF, 32'h0);
        check("raw timer", rd & 32'h4, 32'h4);
        $display("velocity test done");
    endtask
    initial begin
        {psel, pen, pwr, erq, rst_n} = 5'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        n_errors = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_pos;
        t_irq;
        t_index;
        t_mode;
        t_vel;
        report_and_stop;
    end
endmodule // qep_top_test
